// ### shared/swd_regs.svh
// reset values and decode constants for the shift value decoder
`ifndef SWD_REGS_SVH
`define SWD_REGS_SVH
`define SWD_SSV_RESET 7'h40
`define SWD_ZERO_LIMIT 7'h20
`define SWD_FULL_LIMIT 7'h60
`define SWD_TAP_OFFSET 7'h20
`define SWD_TAP_ZERO 7'h00
`define SWD_TAP_FULL 7'h40
`define SWD_TAP_COUNT 65
`define SWD_CMD_VALID 8'h00
`define SWD_TAP_MID 7'h20
`define SWD_RD_RESET 8'h00
`endif

// ### shared/swd_pkg.sv
// types shared by the shift value decoder
package swd_pkg;
	typedef enum logic [1:0] {
		SWD_IDLE,
		SWD_ARMED,
		SWD_ACK_HIGH
	} swd_wr_state_t;
	typedef struct packed {
		logic [6:0] shift_value;
		logic [6:0] pending;
		swd_wr_state_t wr_state;
		logic [7:0] rd_data;
		logic rd_valid;
	} swd_state_t;
endpackage

// ### shared/swd_tap_if.sv
// tap value carried from the register core to the one-hot switch decoder
interface swd_tap_if;
	logic [6:0] tap;
	logic [64:0] sw;
	modport src (output tap, input sw);
	modport dec (input tap, output sw);
endinterface

// ### core/swd_onehot.sv
// one-hot ladder switch decoder for the tap value
`include "swd_regs.svh"
module swd_onehot
	import swd_pkg::*;
#(
	parameter int TAPS = `SWD_TAP_COUNT
) (
	swd_tap_if.dec tif
);
	genvar g;
	generate
		for (g = 0; g < TAPS; g++) begin : g_sw
			assign tif.sw[g] = (tif.tap == 7'(g)); // R8
		end
	endgenerate
endmodule

// ### core/swd_decoder.sv
// serial shift value register and tap select decoder
// Contract
// R1: only the low seven bits of a written data byte are stored, the top bit is dropped.
// R2: a stored value of 20h or less gives tap select 00h.
// R3: a stored value of 60h or more gives tap select 40h.
// R4: stored values 21h through 5Fh give tap select equal to the value minus 20h.
// R5: stored value 40h gives tap 20h and is the power-on value.
// R6: writing C0h reads back 40h and gives the same tap as writing 40h.
// R7: writes update the stored value, reads return it, never the tap select.
// R8: the tap select addresses 65 positions and closes exactly one switch.
// R9: new data takes effect on the falling edge of the acknowledge after the last byte.
// R10: reset loads the stored value with 40h, giving tap 20h.
// R11: a non-zero command code blocks both the write and the read.
// R12: read data carries a zero top bit followed by the seven stored bits.
// R13: the tap select is combinational from the stored value alone.
`include "swd_regs.svh"
module swd_decoder
	import swd_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// write side from the bus engine
	input wire logic wr_byte_i,
	input wire logic [7:0] wr_data_i,
	input wire logic ack_i,
	input wire logic abort_i,
	// command code and read path
	input wire logic [7:0] cmd_code_i,
	input wire logic rd_req_i,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	// ladder side
	output logic [6:0] tap_o,
	output logic [64:0] switch_o,
	output logic [6:0] shift_value_o
);
	logic rst_meta_q;
	logic rst_n_q;
	swd_state_t st_q;
	swd_state_t st_d;
	logic cmd_ok;
	logic [6:0] tap_c;
	logic rd_take;
	swd_tap_if tif ();

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	assign cmd_ok = (cmd_code_i == `SWD_CMD_VALID);
	assign rd_take = rd_req_i && cmd_ok; // R11

	// the byte is held until its acknowledge falls; a stop or restart before the acknowledge rises drops it
	always_comb begin
		st_d = st_q;
		st_d.rd_valid = rd_take; // R11
		if (rd_take) begin
			st_d.rd_data = {1'b0, st_q.shift_value}; // R12 R7
		end
		case (st_q.wr_state)
			SWD_IDLE: begin
				if (wr_byte_i && cmd_ok) begin // R11
					st_d.pending = wr_data_i[6:0]; // R1 R6
					st_d.wr_state = ack_i ? SWD_ACK_HIGH : SWD_ARMED;
				end
			end
			SWD_ARMED: begin
				if (abort_i) begin
					st_d.wr_state = SWD_IDLE;
				end else if (ack_i) begin
					st_d.wr_state = SWD_ACK_HIGH;
				end
			end
			SWD_ACK_HIGH: begin
				if (!ack_i) begin
					st_d.shift_value = st_q.pending; // R9 R7
					st_d.wr_state = SWD_IDLE;
				end
			end
			default: st_d.wr_state = SWD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q.shift_value <= `SWD_SSV_RESET; // R10 R5
			st_q.pending <= `SWD_SSV_RESET;
			st_q.wr_state <= SWD_IDLE;
			st_q.rd_data <= `SWD_RD_RESET;
			st_q.rd_valid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// pure function of the stored value only
	always_comb begin
		if (st_q.shift_value <= `SWD_ZERO_LIMIT) begin
			tap_c = `SWD_TAP_ZERO; // R2
		end else if (st_q.shift_value >= `SWD_FULL_LIMIT) begin
			tap_c = `SWD_TAP_FULL; // R3
		end else begin
			tap_c = st_q.shift_value - `SWD_TAP_OFFSET; // R4 R13
		end
	end

	assign tif.tap = tap_c;
	swd_onehot #(.TAPS(`SWD_TAP_COUNT)) u_onehot (.tif(tif));

	assign tap_o = tap_c;
	assign switch_o = tif.sw;
	assign shift_value_o = st_q.shift_value;
	assign rd_data_o = st_q.rd_data;
	assign rd_valid_o = st_q.rd_valid;

	a_tap_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		st_q.shift_value <= 7'h20 |-> tap_o == 7'h00) else $error("tap not zero"); // R2
	a_tap_full: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		st_q.shift_value >= 7'h60 |-> tap_o == 7'h40) else $error("tap not full"); // R3
	a_tap_mid: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		(st_q.shift_value > 7'h20 && st_q.shift_value < 7'h60)
		|-> tap_o == st_q.shift_value - 7'h20) else $error("tap offset wrong"); // R4
	a_one_hot: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		$onehot(switch_o) && switch_o[tap_o]) else $error("switch not one-hot"); // R8
	a_rd_msb: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		rd_req_i && cmd_ok |=> rd_valid_o && rd_data_o == {1'b0, $past(st_q.shift_value)})
		else $error("read data wrong"); // R12
	a_rd_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		!(rd_req_i && cmd_ok) |=> !rd_valid_o) else $error("read not blocked"); // R11
	sequence s_wr_taken;
		st_q.wr_state == SWD_IDLE && wr_byte_i && cmd_ok && !ack_i;
	endsequence
	sequence s_ack_fall;
		ack_i && !abort_i ##1 ack_i ##1 !ack_i;
	endsequence
	a_wr_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_wr_taken ##1 s_ack_fall |=> shift_value_o == $past(wr_data_i[6:0], 4))
		else $error("write not latched"); // R9
	a_hold_val: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		st_q.wr_state != SWD_ACK_HIGH |=> $stable(shift_value_o)) else $error("value moved"); // R13
	a_reset_val: assert property (@(posedge core_clk_i)
		$rose(rst_n_q) |-> shift_value_o == 7'h40 && tap_o == 7'h20)
		else $error("reset value wrong"); // R10
	a_reset_sw: assert property (@(posedge core_clk_i)
		$rose(rst_n_q) |-> switch_o[`SWD_TAP_MID])
		else $error("reset switch wrong"); // R10

	// the read data moves only on an accepted request
	a_rd_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		!rd_take |=> $stable(rd_data_o))
		else $error("read data moved"); // R12

	a_rd_refuse: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		rd_req_i && !cmd_ok |=> !rd_valid_o && $stable(rd_data_o))
		else $error("refused read answered"); // R11

	a_rd_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		rd_data_o[7] == 1'b0)
		else $error("read top bit set"); // R12

	a_rd_source: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		rd_valid_o |-> rd_data_o == {1'b0, $past(shift_value_o)})
		else $error("read not from register"); // R7

	// a byte is taken only while idle and only under command code zero
	sequence s_byte_ok;
		st_q.wr_state == SWD_IDLE && wr_byte_i && cmd_ok;
	endsequence
	sequence s_byte_refused;
		st_q.wr_state == SWD_IDLE && wr_byte_i && !cmd_ok;
	endsequence

	a_wr_low7: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_byte_ok |=> st_q.pending == $past(wr_data_i[6:0]))
		else $error("pending byte wrong"); // R1

	a_wr_refuse: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_byte_refused |=> st_q.wr_state == SWD_IDLE && $stable(shift_value_o))
		else $error("refused byte taken"); // R11

	// stop or restart before the acknowledge loses the byte
	sequence s_armed_abort;
		st_q.wr_state == SWD_ARMED && abort_i;
	endsequence

	a_abort_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_armed_abort |=> st_q.wr_state == SWD_IDLE && $stable(shift_value_o))
		else $error("aborted byte kept"); // R9

	a_pend_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		st_q.wr_state != SWD_IDLE |=> $stable(st_q.pending))
		else $error("pending byte moved"); // R9

	// commit waits for the acknowledge to fall, not for it to rise
	sequence s_ack_hold;
		st_q.wr_state == SWD_ACK_HIGH && ack_i;
	endsequence
	sequence s_ack_drop;
		st_q.wr_state == SWD_ACK_HIGH && !ack_i;
	endsequence

	a_ack_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_ack_hold |=> st_q.wr_state == SWD_ACK_HIGH && $stable(shift_value_o))
		else $error("commit before ack fell"); // R9

	a_ack_commit: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		s_ack_drop |=> st_q.wr_state == SWD_IDLE && shift_value_o == $past(st_q.pending))
		else $error("commit missing"); // R9

	a_tap_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		tap_o <= `SWD_TAP_FULL)
		else $error("tap out of range"); // R8

	a_mid_scale: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		shift_value_o == `SWD_SSV_RESET |-> tap_o == `SWD_TAP_MID)
		else $error("mid-scale tap wrong"); // R5

	// the ladder moves only when the stored value moves
	a_tap_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		$changed(tap_o) |-> $changed(shift_value_o))
		else $error("tap moved alone"); // R13

	a_sw_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
		$changed(switch_o) |-> $changed(tap_o))
		else $error("switch moved alone"); // R8
endmodule

// ### test/swd_host.sv
// bus engine model driving byte, acknowledge and read strobes
module swd_host (
	// clock
	input wire logic core_clk_i,
	// strobes to the decoder
	output logic wr_byte_o,
	output logic [7:0] wr_data_o,
	output logic ack_o,
	output logic abort_o,
	output logic [7:0] cmd_o,
	output logic rd_req_o,
	// read answer from the decoder
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{wr_byte_o, ack_o, abort_o, rd_req_o} = 4'h0;
		wr_data_o = 8'h00;
		cmd_o = 8'h00;
	end
	// released data is inverted so a stale byte cannot pass
	task automatic put(input logic [7:0] d, input logic drop);
		@(posedge core_clk_i) #1;
		wr_byte_o = 1'b1;
		wr_data_o = d;
		@(posedge core_clk_i) #1;
		wr_byte_o = 1'b0;
		wr_data_o = ~d;
		abort_o = drop;
		ack_o = !drop;
		repeat (2) @(posedge core_clk_i);
		#1 abort_o = 1'b0;
		ack_o = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask
	// answer is taken while the one-cycle valid stands
	task automatic read(output logic v, output logic [7:0] d);
		@(posedge core_clk_i) #1;
		rd_req_o = 1'b1;
		@(posedge core_clk_i) #1;
		rd_req_o = 1'b0;
		v = rd_valid_i;
		d = rd_data_i;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	task automatic code(input logic [7:0] c);
		@(posedge core_clk_i) #1;
		cmd_o = c;
	endtask
endmodule

// ### test/shift_value_to_tap_decoder_test.sv
// self-checking bench for the shift value decoder
module shift_value_to_tap_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 0;
	logic nrst_i = 1;
	logic wr_byte, ack, abort, rd_req, rd_valid;
	logic [7:0] wr_data, cmd, rd_data;
	logic [6:0] tap, ssv, s, t;
	logic [64:0] sw;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] wv[8] = '{8'hA0, 8'h21, 8'hC0, 8'h5F, 8'h60, 8'hFF, 8'h00, 8'hDF};
	swd_host host_u (.core_clk_i(core_clk_i), .wr_byte_o(wr_byte), .wr_data_o(wr_data),
		.ack_o(ack), .abort_o(abort), .cmd_o(cmd), .rd_req_o(rd_req),
		.rd_valid_i(rd_valid), .rd_data_i(rd_data));
	swd_decoder dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wr_byte_i(wr_byte),
		.wr_data_i(wr_data), .ack_i(ack), .abort_i(abort), .cmd_code_i(cmd),
		.rd_req_i(rd_req), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .tap_o(tap),
		.switch_o(sw), .shift_value_o(ssv));
	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input string nm, input logic [64:0] e, input logic [64:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic look(input logic [7:0] d);
		logic v;
		logic [7:0] r;
		s = d[6:0];
		t = s <= 7'h20 ? 7'h00 : s >= 7'h60 ? 7'h40 : s - 7'h20;
		chk("shift value", 65'(s), 65'(ssv));
		chk("tap", 65'(t), 65'(tap));
		chk("switch", 65'h1 << t, sw);
		host_u.read(v, r);
		chk("read valid", 65'(cmd == 8'h00), 65'(v));
		chk("read data", 65'({1'b0, s}), 65'(r));
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		// a real falling edge, so the reset flops leave the unknown state at once
		#1 nrst_i = 0;
		repeat (4) @(posedge core_clk_i);
		#1 nrst_i = 1;
		repeat (3) @(posedge core_clk_i);
		#1;
		look(8'h40);
		foreach (wv[i]) begin
			host_u.put(wv[i], 1'b0);
			look(wv[i]);
		end
		// byte dropped before acknowledge
		host_u.put(8'h7F, 1'b1);
		look(8'hDF);
		host_u.put(8'h40, 1'b0);
		look(8'h40);
		host_u.code(8'h01);
		host_u.put(8'h7F, 1'b0);
		look(8'h40);
		host_u.code(8'h00);
		host_u.put(8'hB3, 1'b0);
		look(8'hB3);
		// reset in mid-run must bring back mid-scale
		nrst_i = 0;
		repeat (2) @(posedge core_clk_i);
		#1 nrst_i = 1;
		repeat (3) @(posedge core_clk_i);
		#1;
		look(8'h40);
		end_sim();
	end
endmodule
